// ==== common/lofc_cfg.svh ====
// offsets, field positions, reset values and constants of the lvds format block
`ifndef LOFC_CFG_SVH
`define LOFC_CFG_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define LOFC_IDX_POL_FMT     8'h18
`define LOFC_IDX_CM_SWING    8'h19
`define LOFC_IDX_ORDER_TERM  8'h1A
`define LOFC_IDX_CM_TRIM     8'h1B

// ***************************************************************
// field positions
// ***************************************************************
`define LOFC_B_VALID_NEG     7
`define LOFC_B_LSYNC_NEG     6
`define LOFC_B_FSYNC_NEG     5
`define LOFC_B_WIDE          3
`define LOFC_B_PACK          1
`define LOFC_B_CM_SEL        6
`define LOFC_B_SWING_LSB     2
`define LOFC_B_MIRROR        5
`define LOFC_B_TERM          1
`define LOFC_B_TRIM_LSB      4

// ***************************************************************
// reset values and writable masks
// ***************************************************************
`define LOFC_RST_POL_FMT     8'h70
`define LOFC_RST_CM_SWING    8'h04
`define LOFC_RST_ORDER_TERM  8'h02
`define LOFC_RST_CM_TRIM     8'h00
`define LOFC_MSK_POL_FMT     8'hFA
`define LOFC_MSK_CM_SWING    8'h4C
`define LOFC_MSK_ORDER_TERM  8'h22
`define LOFC_MSK_CM_TRIM     8'h30

// ***************************************************************
// link constants
// ***************************************************************
`define LOFC_CLK_WORD        7'h63
`define LOFC_SYNC_WIDTH      28

`endif

// ==== common/lofc_pkg.sv ====
// types shared by the lvds format block
package lofc_pkg;
  typedef logic [6:0] lofc_lane_t;
  typedef logic [7:0] lofc_byte_t;
  typedef logic [1:0] lofc_idx_t;
endpackage : lofc_pkg

// ==== rtl/lofc_pin_sync.sv ====
// three-flop pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
`default_nettype none

module lofc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  // ***************************************************************
  // per-bit chain
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // first stage feeds only the second
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= pin[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // a change counts once stages two and three agree
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          level[g] <= 1'b0;
          rise[g]  <= 1'b0;
        end else begin
          rise[g] <= (s2 == s3) && s3 && !level[g];
          if (s2 == s3) begin
            level[g] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule : lofc_pin_sync

`default_nettype wire

// ==== rtl/lofc_lvds_format.sv ====
// lvds output format control with ahb-lite register slave
//
// Notes on behaviour
// R1: pixel valid high when active unless inverted
// R2: line sync low-active by default, selectable
// R3: frame sync low-active by default, selectable
// R4: software leaves reserved bit four at one
// R5: depth bit picks 18/24 bpp, lane3 enable
// R6: packing bit picks msb or lsb on lane3
// R7: software keeps packing zero for 18-bit input
// R8: packing one, narrow: drop two colour lsbs
// R9: mirror swaps lanes 0/3 and 1/clock
// R10: software sets trim 01 with low common level
// R11: swing resets 01, termination resets 1
// R12: two-bit common level trim driven out
// R13: fields read/write, reset values, unused read zero
`timescale 1ns/100ps
`default_nettype none

`include "lofc_cfg.svh"

module lofc_lvds_format
  import lofc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // incoming pixel stream, timed by the pixel clock pin
  input  wire logic        pix_clk_in,
  input  wire logic        pixel_valid,
  input  wire logic        line_sync,
  input  wire logic        frame_sync,
  input  wire logic [7:0]  pixel_red,
  input  wire logic [7:0]  pixel_green,
  input  wire logic [7:0]  pixel_blue,
  // lane words, bit 6 sent first
  output lofc_lane_t       lane0_pos,
  output lofc_lane_t       lane1_pos,
  output lofc_lane_t       lane2_pos,
  output lofc_lane_t       lane3_pos,
  output lofc_lane_t       fwd_clock_pos,
  output logic             lane_word_strobe,
  output logic             lane3_enable,
  // analogue output stage settings
  output logic [1:0]       output_swing_select,
  output logic             output_termination_select,
  output logic             output_common_level_select,
  output logic [1:0]       output_common_level_trim
);

  // ***************************************************************
  // decode helpers
  // ***************************************************************

  // the four indices are consecutive, so bits 3:2 pick the register
  function automatic logic [2:0] decode_index(input logic [31:0] addr);
    logic [31:0] base;
    base = {22'h000000, `LOFC_IDX_POL_FMT, 2'b00};
    decode_index = {(addr[31:4] == base[31:4]) && (addr[1:0] == 2'b00), addr[3:2]};
  endfunction : decode_index

  // writable bits per register; the rest read zero
  function automatic lofc_byte_t mask_of(input lofc_idx_t idx);
    case (idx)
      2'd0:    mask_of = `LOFC_MSK_POL_FMT;
      2'd1:    mask_of = `LOFC_MSK_CM_SWING;
      2'd2:    mask_of = `LOFC_MSK_ORDER_TERM;
      default: mask_of = `LOFC_MSK_CM_TRIM;
    endcase
  endfunction : mask_of

  // ***************************************************************
  // bus address phase
  // ***************************************************************
  logic       accept;
  logic [2:0] hit_idx;
  logic       wr_pend;
  lofc_idx_t  wr_idx;
  lofc_byte_t regs [4];

  assign accept  = hsel && htrans[1] && hready;
  assign hit_idx = decode_index(haddr);

  // remember a mapped write for its data phase; unmapped writes vanish
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx  <= 2'd0;
    end else if (hready) begin
      wr_pend <= accept && hwrite && hit_idx[2];
      wr_idx  <= hit_idx[1:0];
    end
  end

  // zero wait states, always okay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ***************************************************************
  // register file
  // ***************************************************************

  // reserved bit four is writable like the rest; software keeps it at one (see R4)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs[0] <= `LOFC_RST_POL_FMT;   // see R13
      regs[1] <= `LOFC_RST_CM_SWING;  // see R11
      regs[2] <= `LOFC_RST_ORDER_TERM;
      regs[3] <= `LOFC_RST_CM_TRIM;
    end else if (wr_pend) begin
      regs[wr_idx] <= hwdata[7:0] & mask_of(wr_idx); // see R13
    end
  end

  // read data registered in the address phase; a write still in its
  // data phase to the same register is forwarded so no stale value leaks
  lofc_byte_t next_rd_byte;
  always_comb begin
    next_rd_byte = 8'h00;
    if (hit_idx[2]) begin
      if (wr_pend && (wr_idx == hit_idx[1:0])) begin
        next_rd_byte = hwdata[7:0] & mask_of(wr_idx);
      end else begin
        next_rd_byte = regs[hit_idx[1:0]]; // see R13
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= {24'h000000, next_rd_byte};
    end
  end

  // ***************************************************************
  // configuration fields
  // ***************************************************************
  logic cfg_valid_neg;
  logic cfg_lsync_neg;
  logic cfg_fsync_neg;
  logic cfg_wide;
  logic cfg_pack;
  logic cfg_mirror;

  assign cfg_valid_neg = regs[0][`LOFC_B_VALID_NEG];
  assign cfg_lsync_neg = regs[0][`LOFC_B_LSYNC_NEG];
  assign cfg_fsync_neg = regs[0][`LOFC_B_FSYNC_NEG];
  assign cfg_wide      = regs[0][`LOFC_B_WIDE];
  assign cfg_pack      = regs[0][`LOFC_B_PACK];
  assign cfg_mirror    = regs[2][`LOFC_B_MIRROR];

  // analogue settings mirror the register bits, one flop later;
  // trim is not tied to the common level select, software owns that pairing (see R10)
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      output_swing_select        <= 2'b01;
      output_termination_select  <= 1'b1;
      output_common_level_select <= 1'b0;
      output_common_level_trim   <= 2'b00;
    end else begin
      output_swing_select        <= regs[1][`LOFC_B_SWING_LSB +: 2]; // see R11
      output_termination_select  <= regs[2][`LOFC_B_TERM];           // see R11
      output_common_level_select <= regs[1][`LOFC_B_CM_SEL];
      output_common_level_trim   <= regs[3][`LOFC_B_TRIM_LSB +: 2];  // see R12
    end
  end

  // ***************************************************************
  // pixel pin sampling
  // ***************************************************************
  logic [`LOFC_SYNC_WIDTH-1:0] pin_level;
  logic [`LOFC_SYNC_WIDTH-1:0] pin_rise;

  // data pins take the same path as the clock pin so they line up;
  // data must be steady some 40 ns around the pixel clock rise
  lofc_pin_sync #(
    .WIDTH (`LOFC_SYNC_WIDTH)
  ) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pin   ({pix_clk_in, pixel_valid, line_sync, frame_sync,
             pixel_red, pixel_green, pixel_blue}),
    .level (pin_level),
    .rise  (pin_rise)
  );

  logic       pix_edge;
  logic       in_valid;
  logic       in_lsync;
  logic       in_fsync;
  lofc_byte_t in_red;
  lofc_byte_t in_green;
  lofc_byte_t in_blue;

  assign pix_edge = pin_rise[27];
  assign in_valid = pin_level[26];
  assign in_lsync = pin_level[25];
  assign in_fsync = pin_level[24];
  assign in_red   = pin_level[23:16];
  assign in_green = pin_level[15:8];
  assign in_blue  = pin_level[7:0];

  // ***************************************************************
  // lane packing
  // ***************************************************************
  logic [5:0] r6;
  logic [5:0] g6;
  logic [5:0] b6;
  logic [1:0] r2;
  logic [1:0] g2;
  logic [1:0] b2;
  logic       out_valid;
  logic       out_lsync;
  logic       out_fsync;
  lofc_lane_t word0;
  lofc_lane_t word1;
  lofc_lane_t word2;
  lofc_lane_t word3;

  // colour split between the three base lanes and the fourth lane
  always_comb begin
    if (cfg_pack || !cfg_wide) begin
      // lsb packing, or narrow output: base lanes carry the top six bits
      r6 = in_red[7:2];                      // see R8
      g6 = in_green[7:2];
      b6 = in_blue[7:2];
      r2 = in_red[1:0];                      // see R6
      g2 = in_green[1:0];
      b2 = in_blue[1:0];
    end else begin
      // msb packing: base lanes carry the low six, lane three the top two
      r6 = in_red[5:0];
      g6 = in_green[5:0];
      b6 = in_blue[5:0];
      r2 = in_red[7:6];                      // see R6
      g2 = in_green[7:6];
      b2 = in_blue[7:6];
    end
  end

  // control levels after polarity selection
  assign out_valid = in_valid ^ cfg_valid_neg; // see R1
  assign out_lsync = in_lsync ^ cfg_lsync_neg; // see R2
  assign out_fsync = in_fsync ^ cfg_fsync_neg; // see R3

  always_comb begin
    word0 = {g6[0], r6};
    word1 = {b6[1:0], g6[5:1]};
    word2 = {out_valid, out_fsync, out_lsync, b6[5:2]};
    // disabled fourth lane sends an idle zero word
    word3 = cfg_wide ? {1'b0, b2, g2, r2} : 7'h00; // see R5 see R8
  end

  // ***************************************************************
  // lane output registers
  // ***************************************************************

  // words change only on a pixel clock rise; mirror remaps the pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lane0_pos     <= 7'h00;
      lane1_pos     <= 7'h00;
      lane2_pos     <= 7'h00;
      lane3_pos     <= 7'h00;
      fwd_clock_pos <= 7'h00;
    end else if (pix_edge) begin
      if (cfg_mirror) begin
        lane0_pos     <= word3;           // see R9
        lane3_pos     <= word0;           // see R9
        lane1_pos     <= `LOFC_CLK_WORD;  // see R9
        fwd_clock_pos <= word1;           // see R9
      end else begin
        lane0_pos     <= word0;
        lane3_pos     <= word3;
        lane1_pos     <= word1;
        fwd_clock_pos <= `LOFC_CLK_WORD;
      end
      lane2_pos <= word2;
    end
  end

  // strobe marks fresh words; lane enable follows the depth bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lane_word_strobe <= 1'b0;
      lane3_enable     <= 1'b0;
    end else begin
      lane_word_strobe <= pix_edge;
      lane3_enable     <= cfg_wide; // see R5
    end
  end

  // hsize is accepted but only whole-word transfers are expected
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0], hwdata[31:8]};

endmodule : lofc_lvds_format

`default_nettype wire

// ==== test/lofc_lvds_format_props.sv ====
// port checker of the lvds format block
`timescale 1ns/100ps
`default_nettype none

module lofc_lvds_format_props
  import lofc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        pix_clk_in,
  input wire lofc_lane_t  lane0_pos,
  input wire lofc_lane_t  lane1_pos,
  input wire lofc_lane_t  lane3_pos,
  input wire lofc_lane_t  fwd_clock_pos,
  input wire logic        lane_word_strobe,
  input wire logic        lane3_enable,
  input wire logic [1:0]  output_swing_select,
  input wire logic        output_termination_select,
  input wire logic        output_common_level_select,
  input wire logic [1:0]  output_common_level_trim
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic        wr_q;
  logic [31:0] adr_q;

  // write data phase tracker; hwdata only stands in the data phase itself,
  // so the properties take it with $past at that edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      adr_q <= 32'h0;
    end else begin
      wr_q  <= hsel && htrans[1] && hready && hwrite;
      adr_q <= haddr;
    end
  end

  // ********************
  // properties
  // ********************
  property p_rst_analog;
    $rose(rst_n) |-> output_swing_select == 2'h1 && output_termination_select;
  endproperty
  a_rst_analog: assert property (p_rst_analog) else $error("analog reset wrong");
  property p_ready;
    $past(rst_n) |-> hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or error");
  property p_rd_high;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("unused read bits set");
  property p_swing;
    // register lands at the data phase end, the output flop one edge later
    wr_q && hready && adr_q == 32'h64 |-> ##2
      output_swing_select == $past(hwdata[3:2], 2) &&
      output_common_level_select == $past(hwdata[6], 2);
  endproperty
  a_swing: assert property (p_swing) else $error("swing or level not applied");
  property p_trim;
    wr_q && hready && adr_q == 32'h6C |-> ##2
      output_common_level_trim == $past(hwdata[5:4], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied");
  property p_pin;
    $rose(pix_clk_in) |-> ##[2:6] lane_word_strobe;
  endproperty
  a_pin: assert property (p_pin) else $error("no word after pixel clock");
  property p_gap;
    lane_word_strobe |=> !lane_word_strobe [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("extra word strobe");
  property p_lane3_off;
    lane_word_strobe && !lane3_enable && fwd_clock_pos == 7'h63 && lane1_pos != 7'h63
      |-> lane3_pos == 7'h0;
  endproperty
  a_lane3_off: assert property (p_lane3_off) else $error("fourth lane not idle");
  property p_mirror;
    lane_word_strobe && !lane3_enable && lane1_pos == 7'h63 && fwd_clock_pos != 7'h63
      |-> lane0_pos == 7'h0;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirrored lane wrong");
endmodule : lofc_lvds_format_props

bind lofc_lvds_format lofc_lvds_format_props lofc_lvds_format_props_inst (
  .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .pix_clk_in, .lane0_pos, .lane1_pos, .lane3_pos, .fwd_clock_pos,
  .lane_word_strobe, .lane3_enable, .output_swing_select, .output_termination_select,
  .output_common_level_select, .output_common_level_trim
);
`default_nettype wire

// ==== test/lofc_panel_model.sv ====
// flat panel model catching each lane word set
`timescale 1ns/100ps
`default_nettype none

module lofc_panel_model
  import lofc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       strobe,
  input  wire lofc_lane_t lane0,
  input  wire lofc_lane_t lane1,
  input  wire lofc_lane_t lane2,
  input  wire lofc_lane_t lane3,
  input  wire lofc_lane_t fwd_clock,
  output logic [34:0]     word,
  output logic            got
);
  // latch on the strobe; a real panel needs settled pins, so read one edge late
  always_ff @(posedge clock) begin
    got <= strobe;
    if (strobe)
      word <= {lane0, lane1, lane2, lane3, fwd_clock};
  end
endmodule : lofc_panel_model
`default_nettype wire

// ==== test/tb_lofc_lvds_format.sv ====
// self-checking bench of the lvds format block
`timescale 1ns/100ps
`default_nettype none

module tb_lofc_lvds_format
  import lofc_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_vld = 1'b0;
  logic pix_clk_in = 1'b0, pixel_valid = 1'b0, line_sync = 1'b0, frame_sync = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  pixel_red = 8'h0, pixel_green = 8'h0, pixel_blue = 8'h0, pf;
  logic [7:0]  rv [4] = '{8'h70, 8'h04, 8'h02, 8'h00};
  logic [7:0]  wv [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hDF};
  logic [7:0]  mk [4] = '{8'hFA, 8'h4C, 8'h22, 8'h10};
  wire logic   hreadyout, hresp, lane_word_strobe, lane3_enable, got;
  wire logic   output_termination_select, output_common_level_select;
  wire logic [1:0]  output_swing_select, output_common_level_trim;
  wire logic [31:0] hrdata;
  wire logic [34:0] word;
  wire lofc_lane_t  lane0_pos, lane1_pos, lane2_pos, lane3_pos, fwd_clock_pos;
  logic [34:0] q_ln [$];
  logic [31:0] q_rd [$];
  int cycles, num_errors, total_checks;

  lofc_lvds_format lofc_lvds_format_inst (
    .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pix_clk_in, .pixel_valid,
    .line_sync, .frame_sync, .pixel_red, .pixel_green, .pixel_blue, .lane0_pos,
    .lane1_pos, .lane2_pos, .lane3_pos, .fwd_clock_pos, .lane_word_strobe, .lane3_enable,
    .output_swing_select, .output_termination_select, .output_common_level_select,
    .output_common_level_trim);
  lofc_panel_model lofc_panel_model_inst (
    .clock, .strobe(lane_word_strobe), .lane0(lane0_pos), .lane1(lane1_pos),
    .lane2(lane2_pos), .lane3(lane3_pos), .fwd_clock(fwd_clock_pos), .word, .got);

  always #5 clock = ~clock;

  // ********************
  // tasks
  // ********************
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // one single word transfer; for a read d is the value expected back
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_vld <= !wr;
    if (!wr)
      q_rd.push_back(d);
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd_vld <= 1'b0;
  endtask : bus

  // expected pins: {lane0, lane1, lane2, lane3, forwarded clock}
  function automatic logic [34:0] lanes_exp(input logic [7:0] f, input logic m,
                                            input logic [23:0] p, input logic [2:0] c);
    logic [5:0] r6, g6, b6;
    logic [6:0] a0, a1, a2, a3;
    r6 = (f[1] || !f[3]) ? p[23:18] : p[21:16];
    g6 = (f[1] || !f[3]) ? p[15:10] : p[13:8];
    b6 = (f[1] || !f[3]) ? p[7:2] : p[5:0];
    a3 = !f[3] ? 7'h0 : f[1] ? {1'b0, p[1:0], p[9:8], p[17:16]}
                             : {1'b0, p[7:6], p[15:14], p[23:22]};
    a0 = {g6[0], r6};
    a1 = {b6[1:0], g6[5:1]};
    a2 = {c ^ {f[7], f[5], f[6]}, b6[5:2]};
    return m ? {a3, 7'h63, a2, a0, a1} : {a0, a1, a2, a3, 7'h63};
  endfunction : lanes_exp

  // one pixel period of 125 ns; the link clock stands still between calls
  task automatic pixel(input logic m);
    logic [23:0] p;
    logic [2:0]  c;
    p = 24'($urandom);
    c = 3'($urandom);
    {pixel_red, pixel_green, pixel_blue} <= p;
    {pixel_valid, frame_sync, line_sync} <= c;
    q_ln.push_back(lanes_exp(pf, m, p, c));
    #62.5 pix_clk_in <= 1'b1;
    #62.5 pix_clk_in <= 1'b0;
  endtask : pixel

  // results are compared oldest first as they appear
  always @(posedge clock) begin
    if (rd_vld && hreadyout === 1'b1)
      check(35'(hrdata), 35'(q_rd.pop_front()));
    if (got === 1'b1)
      check(word, q_ln.pop_front());
  end

  // hang guard well above the some five hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'hE7B0));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 32'h60 + 4 * i, {24'h0, rv[i]});
      bus(1'b1, 32'h60 + 4 * i, {24'hFFFFFF, wv[i]});
      bus(1'b0, 32'h60 + 4 * i, {24'h0, mk[i]});
    end
    bus(1'b1, 32'h70, 32'hFFFF_FFFF);
    bus(1'b0, 32'h70, 32'h0);
    @(negedge clock);
    check({29'h0, output_swing_select, output_termination_select,
           output_common_level_select, output_common_level_trim}, 35'h3D);
    bus(1'b1, 32'h64, 32'h04);
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, 32'h6C, 32'(j) << 4);
      bus(1'b0, 32'h6C, 32'(j) << 4);
    end
    // depth and packing bits each take both values here, so packing one also meets 18-bit input
    for (int k = 0; k < 8; k++) begin
      pf = {3'($urandom), 1'b1, k[0], 1'b0, k[1], 1'b0};
      bus(1'b1, 32'h60, {24'h0, pf});
      bus(1'b1, 32'h68, {26'h0, k[2], 5'h02});
      @(posedge clock);
      #3;
      repeat (3) pixel(k[2]);
      repeat (6) @(posedge clock);
      check(35'(lane3_enable), 35'(k[0]));
    end
    check(35'(q_ln.size() + q_rd.size()), 35'h0);
    tally_and_finish();
  end
endmodule : tb_lofc_lvds_format
`default_nettype wire
